/* File: rrdfr_defines.svh */
// Purpose: named constants of the relay remote data and fault record block
// Assumes: 50 MHz system clock
// Notes: definitions only
`ifndef RRDFR_DEFINES_SVH
`define RRDFR_DEFINES_SVH

`define RRDFR_CLK_MHZ      50
`define RRDFR_MS_US        1000
`define RRDFR_MS_CYCLES    (`RRDFR_CLK_MHZ * `RRDFR_MS_US)
`define RRDFR_SST_MS       5000

`define RRDFR_ADDR_RST     8'h01
`define RRDFR_ADDR_MIN     16'h0001
`define RRDFR_ADDR_MAX     16'h00fe
`define RRDFR_TIME_MAX     16'hea5f
`define RRDFR_PCT_MAX      16'h03e7
`define RRDFR_PCT_RST      10'h064
`define RRDFR_PCT_UNIT     16'h0064
`define RRDFR_PWD_RST      10'h001

`define RRDFR_V_FAULT_REC  8'h06
`define RRDFR_V_CLR_ERASE  8'h66
`define RRDFR_V_SRC_SEL    8'h96
`define RRDFR_V_PWD_OPEN   8'ha0
`define RRDFR_V_PWD_NEW    8'ha1
`define RRDFR_V_SS_TRIG    8'ha5
`define RRDFR_V_FAULT_CODE 8'ha9
`define RRDFR_V_BUS_ADDR   8'hc8
`define RRDFR_V_FW_VER     8'hcd

`define RRDFR_S_ACTIVE     8'h01
`define RRDFR_S_KNOB       8'h0b
`define RRDFR_S_PCT        8'h15
`define RRDFR_S_REMOTE     8'h1f

`define RRDFR_FC_NONE      8'h00
`define RRDFR_FC_TRIP      8'h04
`define RRDFR_FC_ROM       8'h1e
`define RRDFR_FC_RAM       8'h32
`define RRDFR_FC_LO_X1     8'hc3
`define RRDFR_FC_LO_X5     8'h83
`define RRDFR_FC_LO_X25    8'h43
`define RRDFR_FC_HI_X1     8'hcb
`define RRDFR_FC_HI_X5     8'h8b
`define RRDFR_FC_HI_X25    8'h4b
`define RRDFR_FC_DAC       8'hfd

`define RRDFR_ST_AUTORST   0
`define RRDFR_ST_OVF       1
`define RRDFR_FR_LO_LSB    0
`define RRDFR_FR_HI_LSB    4

`endif

/* File: rrdfr_pkg.sv */
// Purpose: types shared by the relay remote data and fault record block
// Assumes: requests arrive already deframed from the serial link
// Notes: none
package rrdfr_pkg;

	typedef enum logic [3:0] {
		RRDFR_K_VRD    = 4'h0,
		RRDFR_K_VWR    = 4'h1,
		RRDFR_K_SRD    = 4'h2,
		RRDFR_K_SWR    = 4'h3,
		RRDFR_K_EV_RD  = 4'h4,
		RRDFR_K_EV_RR  = 4'h5,
		RRDFR_K_ST_RD  = 4'h6,
		RRDFR_K_ST_WR  = 4'h7,
		RRDFR_K_TM_RD  = 4'h8,
		RRDFR_K_TM_WR  = 4'h9
	} rrdfr_kind_t;

	typedef enum logic {
		RRDFR_SS_IDLE   = 1'b0,
		RRDFR_SS_ACTIVE = 1'b1
	} rrdfr_ss_t;

	typedef struct packed {
		logic              valid;
		rrdfr_kind_t       kind;
		logic [7:0]        addr;
		logic [7:0]        item;
		logic [15:0]       wdata;
	} rrdfr_req_t;

	typedef struct packed {
		logic              valid;
		logic              err;
		logic [31:0]       data;
	} rrdfr_rsp_t;

	typedef struct packed {
		logic              valid;
		logic [3:0]        channel;
		logic [7:0]        code;
	} rrdfr_ev_t;

	typedef struct packed {
		logic [15:0]       time_ms;
		logic [3:0]        channel;
		logic [7:0]        code;
	} rrdfr_evrec_t;

	typedef struct packed {
		logic              valid;
		logic [2:0]        phases;
	} rrdfr_trip_t;

	typedef struct packed {
		logic              trip_path;
		logic              rom;
		logic              ram;
		logic [2:0]        ref_lo;
		logic [2:0]        ref_hi;
		logic              dac_silent;
	} rrdfr_diag_t;

endpackage : rrdfr_pkg

/* File: rrdfr_tick.sv */
// Purpose: one-cycle enable pulse every millisecond
// Assumes: single system clock
// Notes: count is a parameter so simulation can shorten it
`timescale 1ns/1ps
`default_nettype none
module rrdfr_tick #(
	parameter int unsigned CYCLES = 50000
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// enable out
	output logic      tick
);
	localparam int unsigned CW = $clog2(CYCLES);
	logic [CW-1:0] cnt;
	wire logic     wrap = (cnt == CW'(CYCLES - 1));

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt  <= '0;
			tick <= 1'b0;
		end else begin
			cnt  <= wrap ? '0 : cnt + 1'b1;
			tick <= wrap;
		end
	end
endmodule : rrdfr_tick
`default_nettype wire

/* File: rrdfr_scale.sv */
// Purpose: remote effective setting from knob value and percentage
// Assumes: percentage 0..999, at least ten bits wide
// Notes: combinational, constant divider
`timescale 1ns/1ps
`default_nettype none
`include "rrdfr_defines.svh"
module rrdfr_scale #(
	parameter int unsigned KW = 10,
	parameter int unsigned PW = 10
) (
	// operands
	input  wire logic [KW-1:0] knob,
	input  wire logic [PW-1:0] pct,
	// result
	output logic      [KW+3:0] eff
);
	localparam int unsigned MW = KW + PW;
	localparam logic [MW-1:0] UNIT = MW'(`RRDFR_PCT_UNIT);
	wire logic [MW-1:0] prod = MW'(knob) * MW'(pct);
	wire logic [MW-1:0] quo  = prod / UNIT;
	// 999 percent of the largest knob value still fits four extra bits
	assign eff = quo[KW+3:0];
endmodule : rrdfr_scale
`default_nettype wire

/* File: rrdfr_top.sv */
// Purpose: remote data, event register, settings and fault record of a relay module
// Assumes: requests come deframed on the same clock; buttons are raw pins
// Notes: one answer per accepted request, one cycle after it
`timescale 1ns/1ps
`default_nettype none
`include "rrdfr_defines.svh"

// Overview of operation
// - keep a read/write bus address limited to 1 through 254.
// - event read returns time, channel, code; each event delivered once.
// - event re-read repeats the last delivered event any number of times.
// - module state reads 0 normal, 1 auto reset, 2 overflow, 3 both.
// - writing 0 to module state clears it back to normal.
// - seconds-in-minute time in milliseconds, 0 to 59.999, readable and writable.
// - four command codes are reserved for event data exchange.
// - active settings come from knobs or remote values per source select.
// - remote percentages read/write; each scales its knob value.
// - percentage write needs opened password and source select equal to 0.
// - each percentage accepts 0 to 999 regardless of setting range.
// - trigger active with fault indicator lit inhibits all protection.
// - phase fault record is the sum of low-set and high-set phase codes.
// - weights: low L3 1, L2 2, L1 4; high L3 16, L2 32, L1 64.
// - each stage operation updates only its own part of the record.
// - a new value overwrites the previous part, no accumulation.
// - record cleared by both buttons pressed or clear-and-erase write of 1.
// - permanent internal fault lights the indicator and drives supervision relay.
// - fault codes 4 trip path, 30 program memory, 50 data memory.
// - reference too low: 195 at x1, 131 at x5, 67 at x25.
// - reference too high: 203 at x1, 139 at x5, 75 at x25.
// - no converter interrupts reports fault code 253.
module rrdfr_top
	import rrdfr_pkg::*;
#(
	parameter int unsigned N_SET      = 5,
	parameter int unsigned KW         = 10,
	parameter int unsigned PW         = 10,
	parameter int unsigned EV_DEPTH   = 8,
	parameter int unsigned MS_CYCLES  = `RRDFR_MS_CYCLES,
	parameter int unsigned SST_MS     = `RRDFR_SST_MS,
	parameter logic [7:0]  FW_VERSION = 8'h5a  // arbitrary value
) (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        sys_rst,
	// serial bus requests and answers
	input  wire rrdfr_req_t                  req,
	output rrdfr_rsp_t                       rsp,
	// events and protection inputs
	input  wire rrdfr_ev_t                   ev_in,
	input  wire logic                        auto_reset_evt,
	input  wire rrdfr_trip_t                 trip_lo,
	input  wire rrdfr_trip_t                 trip_hi,
	input  wire rrdfr_diag_t                 diag,
	input  wire logic [N_SET-1:0][KW-1:0]    knob_set,
	// front panel pins
	input  wire logic                        step_btn_pin,
	input  wire logic                        reset_btn_pin,
	// settings out
	output logic      [N_SET-1:0][KW+3:0]    active_set,
	output logic      [N_SET-1:0][KW+3:0]    remote_eff,
	// supervision and record
	output logic                             irf_led,
	output logic                             ss_relay,
	output logic                             prot_inhibit,
	output logic      [7:0]                  fault_code,
	output logic      [7:0]                  phase_fault_record
);
	localparam int unsigned AW  = $clog2(EV_DEPTH);
	localparam int unsigned SCW = $clog2(SST_MS + 1);

	function automatic logic set_hit(input logic [7:0] item, input logic [7:0] base);
		set_hit = (item >= base) && (item < base + 8'(N_SET));
	endfunction : set_hit

	function automatic logic [2:0] set_idx(input logic [7:0] item, input logic [7:0] base);
		logic [7:0] d;
		d = item - base;
		set_idx = d[2:0];
	endfunction : set_idx

	function automatic logic [7:0] diag_code(input rrdfr_diag_t d);
		diag_code = d.trip_path  ? `RRDFR_FC_TRIP   :
			    d.rom        ? `RRDFR_FC_ROM    :
			    d.ram        ? `RRDFR_FC_RAM    :
			    d.ref_lo[0]  ? `RRDFR_FC_LO_X1  :
			    d.ref_lo[1]  ? `RRDFR_FC_LO_X5  :
			    d.ref_lo[2]  ? `RRDFR_FC_LO_X25 :
			    d.ref_hi[0]  ? `RRDFR_FC_HI_X1  :
			    d.ref_hi[1]  ? `RRDFR_FC_HI_X5  :
			    d.ref_hi[2]  ? `RRDFR_FC_HI_X25 :
			    d.dac_silent ? `RRDFR_FC_DAC    :
			    `RRDFR_FC_NONE;
	endfunction : diag_code

	// state
	logic [1:0]          step_sync;
	logic [1:0]          rst_sync;
	logic [7:0]          bus_addr;
	logic                src_sel;
	logic [9:0]          pwd;
	logic                pwd_open;
	logic [N_SET-1:0][PW-1:0] pct;
	logic [N_SET-1:0][KW+3:0] eff;
	logic [1:0]          mod_state;
	logic [15:0]         time_ms;
	rrdfr_ss_t           ss_state;
	logic [SCW-1:0]      ss_cnt;
	logic                fault_latched;
	rrdfr_evrec_t        ev_mem [EV_DEPTH];
	rrdfr_evrec_t        last_ev;
	logic [AW-1:0]       wr_ptr;
	logic [AW-1:0]       rd_ptr;
	logic [AW:0]         ev_cnt;
	logic                ms_tick;

	rrdfr_tick #(.CYCLES(MS_CYCLES)) u_tick (
		.clk     (clk),
		.sys_rst (sys_rst),
		.tick    (ms_tick)
	);

	// buttons are asynchronous pins
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			step_sync <= 2'h0;
			rst_sync  <= 2'h0;
		end else begin
			step_sync <= {step_sync[0], step_btn_pin};
			rst_sync  <= {rst_sync[0], reset_btn_pin};
		end
	end
	wire logic btn_clear = step_sync[1] & rst_sync[1];

	// request decode
	wire logic req_mine = req.valid && (req.addr == bus_addr);
	wire logic v_wr     = req_mine && (req.kind == RRDFR_K_VWR);
	wire logic v_rd     = req_mine && (req.kind == RRDFR_K_VRD);
	wire logic s_wr     = req_mine && (req.kind == RRDFR_K_SWR);
	wire logic s_rd     = req_mine && (req.kind == RRDFR_K_SRD);
	wire logic ev_rd    = req_mine && (req.kind == RRDFR_K_EV_RD);
	wire logic ev_rr    = req_mine && (req.kind == RRDFR_K_EV_RR);
	wire logic st_rd    = req_mine && (req.kind == RRDFR_K_ST_RD);
	wire logic st_wr    = req_mine && (req.kind == RRDFR_K_ST_WR);
	wire logic tm_rd    = req_mine && (req.kind == RRDFR_K_TM_RD);
	wire logic tm_wr    = req_mine && (req.kind == RRDFR_K_TM_WR);
	wire logic kind_ok  = v_wr | v_rd | s_wr | s_rd | ev_rd | ev_rr | st_rd | st_wr
			      | tm_rd | tm_wr;
	wire logic [15:0] wd = req.wdata;
	wire logic pct_ok   = wd <= `RRDFR_PCT_MAX;

	wire logic addr_wr  = v_wr && (req.item == `RRDFR_V_BUS_ADDR)
			      && (wd >= `RRDFR_ADDR_MIN) && (wd <= `RRDFR_ADDR_MAX);
	wire logic src_wr   = v_wr && (req.item == `RRDFR_V_SRC_SEL) && (wd <= 16'h0001);
	wire logic popen_wr = v_wr && (req.item == `RRDFR_V_PWD_OPEN) && pct_ok;
	wire logic pnew_wr  = v_wr && (req.item == `RRDFR_V_PWD_NEW) && pct_ok && pwd_open;
	wire logic sst_wr   = v_wr && (req.item == `RRDFR_V_SS_TRIG) && (wd == 16'h0001);
	wire logic clr_wr   = v_wr && (req.item == `RRDFR_V_CLR_ERASE) && (wd == 16'h0001);
	wire logic pct_hit  = set_hit(req.item, `RRDFR_S_PCT);
	wire logic [2:0] pct_i = set_idx(req.item, `RRDFR_S_PCT);
	wire logic pct_wr   = s_wr && pct_hit && pwd_open && !src_sel && pct_ok;
	wire logic st_clr   = st_wr && (wd == 16'h0000);
	wire logic tm_ok    = tm_wr && (wd <= `RRDFR_TIME_MAX);
	wire logic wr_ok    = addr_wr | src_wr | popen_wr | pnew_wr | sst_wr | clr_wr
			      | pct_wr | st_clr | tm_ok;
	wire logic is_wr    = v_wr | s_wr | st_wr | tm_wr;

	// event register: a read pops, so each event leaves once
	wire logic ev_full  = (ev_cnt == (AW+1)'(EV_DEPTH));
	wire logic ev_empty = (ev_cnt == '0);
	wire logic ev_pop   = ev_rd && !ev_empty;
	wire logic ev_push  = ev_in.valid && (!ev_full || ev_pop);
	wire logic ev_ovf   = ev_in.valid && ev_full && !ev_pop;
	wire rrdfr_evrec_t ev_new  = '{time_ms: time_ms, channel: ev_in.channel, code: ev_in.code};
	wire rrdfr_evrec_t ev_head = ev_mem[rd_ptr];

	always_ff @(posedge clk) begin
		if (ev_push)
			ev_mem[wr_ptr] <= ev_new;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_ptr  <= '0;
			rd_ptr  <= '0;
			ev_cnt  <= '0;
			last_ev <= '0;
		end else begin
			wr_ptr <= ev_push ? AW'(wr_ptr + 1'b1) : wr_ptr;
			rd_ptr <= ev_pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
			ev_cnt <= ev_cnt + (AW+1)'(ev_push) - (AW+1)'(ev_pop);
			if (ev_pop)
				last_ev <= ev_head;
		end
	end

	// state bits: a new condition in the clearing cycle is kept
	wire logic [1:0] st_set = {ev_ovf, auto_reset_evt};
	wire logic [1:0] next_mod_state = (st_clr ? 2'h0 : mod_state) | st_set;

	// time of minute
	wire logic [15:0] time_inc = (time_ms == `RRDFR_TIME_MAX) ? 16'h0000 : time_ms + 16'h0001;
	wire logic [15:0] next_time_ms = tm_ok ? wd : (ms_tick ? time_inc : time_ms);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bus_addr  <= `RRDFR_ADDR_RST;
			src_sel   <= 1'b0;
			pwd       <= `RRDFR_PWD_RST;
			pwd_open  <= 1'b0;
			mod_state <= 2'h0;
			time_ms   <= 16'h0000;
		end else begin
			if (addr_wr)
				bus_addr <= wd[7:0];
			if (src_wr)
				src_sel <= wd[0];
			if (popen_wr && wd[9:0] == pwd)
				pwd_open <= 1'b1;
			else if (pnew_wr)
				pwd_open <= 1'b0;
			if (pnew_wr && wd != 16'h0000)
				pwd <= wd[9:0];
			mod_state <= next_mod_state;
			time_ms   <= next_time_ms;
		end
	end

	// remote percentages and the settings in use
	genvar gi;
	generate
		for (gi = 0; gi < N_SET; gi++) begin : g_set
			rrdfr_scale #(.KW(KW), .PW(PW)) u_scale (
				.knob (knob_set[gi]),
				.pct  (pct[gi]),
				.eff  (eff[gi])
			);
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					pct[gi]        <= `RRDFR_PCT_RST;
					active_set[gi] <= '0;
					remote_eff[gi] <= '0;
				end else begin
					if (pct_wr && pct_i == 3'(gi))
						pct[gi] <= wd[PW-1:0];
					remote_eff[gi] <= eff[gi];
					active_set[gi] <= src_sel ? eff[gi] : (KW+4)'(knob_set[gi]);
				end
			end
		end
	endgenerate

	// self-supervision test trigger
	wire logic ss_done = ms_tick && (ss_cnt == SCW'(SST_MS - 1));
	wire logic [7:0] diag_now = diag_code(diag);
	wire logic ss_active = (ss_state == RRDFR_SS_ACTIVE);
	wire logic next_irf  = fault_latched | ss_active;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ss_state <= RRDFR_SS_IDLE;
			ss_cnt   <= '0;
		end else begin
			case (ss_state)
				RRDFR_SS_IDLE: begin
					ss_cnt <= '0;
					if (sst_wr)
						ss_state <= RRDFR_SS_ACTIVE;
				end
				RRDFR_SS_ACTIVE: begin
					ss_cnt <= ms_tick ? SCW'(ss_cnt + 1'b1) : ss_cnt;
					if (ss_done)
						ss_state <= RRDFR_SS_IDLE;
				end
				default: ss_state <= RRDFR_SS_IDLE;
			endcase
		end
	end

	// a permanent fault holds until reset; the first code stays shown
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fault_latched <= 1'b0;
			fault_code    <= `RRDFR_FC_NONE;
			irf_led       <= 1'b0;
			ss_relay      <= 1'b0;
			prot_inhibit  <= 1'b0;
		end else begin
			if (!fault_latched && diag_now != `RRDFR_FC_NONE) begin
				fault_latched <= 1'b1;
				fault_code    <= diag_now;
			end
			irf_led      <= next_irf;
			ss_relay     <= next_irf;
			prot_inhibit <= ss_active && irf_led;
		end
	end

	// phase fault record: each stage rewrites its own part, trip wins over clear
	wire logic rec_clear = btn_clear | clr_wr;
	wire logic [2:0] next_rec_lo = trip_lo.valid ? trip_lo.phases :
		(rec_clear ? 3'h0 : phase_fault_record[`RRDFR_FR_LO_LSB +: 3]);
	wire logic [2:0] next_rec_hi = trip_hi.valid ? trip_hi.phases :
		(rec_clear ? 3'h0 : phase_fault_record[`RRDFR_FR_HI_LSB +: 3]);

	always_ff @(posedge clk) begin
		if (sys_rst)
			phase_fault_record <= 8'h00;
		else
			phase_fault_record <= {1'b0, next_rec_hi, 1'b0, next_rec_lo};
	end

	// read data selection
	wire logic [31:0] v_data =
		(req.item == `RRDFR_V_FAULT_REC)  ? {24'h0, phase_fault_record} :
		(req.item == `RRDFR_V_SRC_SEL)    ? {31'h0, src_sel} :
		(req.item == `RRDFR_V_FAULT_CODE) ? {24'h0, fault_code} :
		(req.item == `RRDFR_V_BUS_ADDR)   ? {24'h0, bus_addr} :
		(req.item == `RRDFR_V_FW_VER)     ? {24'h0, FW_VERSION} : 32'h0;
	wire logic v_known = (req.item == `RRDFR_V_FAULT_REC) | (req.item == `RRDFR_V_SRC_SEL)
		| (req.item == `RRDFR_V_FAULT_CODE) | (req.item == `RRDFR_V_BUS_ADDR)
		| (req.item == `RRDFR_V_FW_VER);
	wire logic act_hit = set_hit(req.item, `RRDFR_S_ACTIVE);
	wire logic knb_hit = set_hit(req.item, `RRDFR_S_KNOB);
	wire logic rem_hit = set_hit(req.item, `RRDFR_S_REMOTE);
	wire logic [31:0] s_data =
		act_hit ? 32'(active_set[set_idx(req.item, `RRDFR_S_ACTIVE)]) :
		knb_hit ? 32'(knob_set[set_idx(req.item, `RRDFR_S_KNOB)]) :
		pct_hit ? 32'(pct[pct_i]) :
		rem_hit ? 32'(remote_eff[set_idx(req.item, `RRDFR_S_REMOTE)]) : 32'h0;
	wire logic s_known = act_hit | knb_hit | pct_hit | rem_hit;
	wire logic [31:0] rd_data =
		v_rd  ? v_data :
		s_rd  ? s_data :
		ev_rd ? (ev_empty ? 32'h0 : 32'(ev_head)) :
		ev_rr ? 32'(last_ev) :
		st_rd ? {30'h0, mod_state} :
		tm_rd ? {16'h0, time_ms} : 32'h0;
	wire logic rd_bad = (v_rd && !v_known) || (s_rd && !s_known);

	always_ff @(posedge clk) begin
		if (sys_rst)
			rsp <= '0;
		else begin
			rsp.valid <= kind_ok;
			rsp.err   <= (is_wr && !wr_ok) || rd_bad;
			rsp.data  <= rd_data;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	addr_range_a: assert property (bus_addr != 8'h00 && bus_addr != 8'hff)
		else $error("bus address out of range");
	ev_once_a: assert property (ev_pop && !ev_push |=> ev_cnt == $past(ev_cnt) - 1'b1)
		else $error("event read did not remove the event");
	ev_reread_a: assert property (ev_pop ##1 !ev_pop ##1 ev_rr |=> rsp.data == $past(rsp.data, 2))
		else $error("re-read differs from last read");
	st_ovf_a: assert property (ev_ovf |=> mod_state[`RRDFR_ST_OVF])
		else $error("overflow not recorded");
	st_clear_a: assert property (st_clr && st_set == 2'h0 |=> mod_state == 2'h0)
		else $error("state not cleared");
	time_range_a: assert property (time_ms <= `RRDFR_TIME_MAX)
		else $error("time beyond one minute");
	pct_guard_a: assert property (pct != $past(pct) |-> $past(pwd_open && !src_sel))
		else $error("percentage written without permission");
	inhibit_irf_a: assert property (prot_inhibit |-> irf_led && $past(ss_active))
		else $error("inhibit without lit indicator");
	rec_low_a: assert property (trip_lo.valid && !trip_hi.valid && !rec_clear
		|=> phase_fault_record[2:0] == $past(trip_lo.phases)
		&& phase_fault_record[6:4] == $past(phase_fault_record[6:4]))
		else $error("low-set record update wrong");
	rec_clear_a: assert property (clr_wr && !trip_lo.valid && !trip_hi.valid
		|=> phase_fault_record == 8'h00)
		else $error("record not cleared");
	foreign_addr_a: assert property (req.valid && req.addr != bus_addr |=> !rsp.valid)
		else $error("answered a foreign address");

	ev_read_c: cover property (ev_pop ##2 ev_rr);
	pct_write_c: cover property (pct_wr);
	ss_test_c: cover property (sst_wr ##1 ss_active);
	rec_both_c: cover property (trip_lo.valid && trip_hi.valid);
endmodule : rrdfr_top
`default_nettype wire

/* File: rrdfr_host_model.sv */
// Purpose: substation communicator model issuing one request at a time
// Assumes: answer is registered at the taking edge and is read 1 ns after it
// Notes: released request lines show inverted address, item and data so stale data cannot pass
`timescale 1ns/1ps
`default_nettype none
module rrdfr_host_model
	import rrdfr_pkg::*;
(
	// clock
	input  wire logic       clk,
	// request bus
	output var rrdfr_req_t  req,
	input  wire rrdfr_rsp_t rsp
);
	initial req = '0;
	task automatic xfer(input rrdfr_kind_t k, input logic [7:0] a, input logic [7:0] it,
		input logic [15:0] wd, output logic got, output logic er, output logic [31:0] dt);
		@(posedge clk);
		req <= '{1'b1, k, a, it, wd};
		@(posedge clk);
		req <= '{1'b0, k, ~a, ~it, ~wd};
		#1;
		got = rsp.valid;
		er = rsp.err;
		dt = rsp.data;
	endtask : xfer
endmodule : rrdfr_host_model
`default_nettype wire

/* File: relay_remote_data_and_fault_record_tb_top.sv */
// Purpose: self-checking bench for the relay remote data block
// Assumes: shortened millisecond and supervision counts
// Notes: diagnostics are walked last, with a reset per code
`timescale 1ns/1ps
`default_nettype none
module relay_remote_data_and_fault_record_tb_top;
	import rrdfr_pkg::*;
	localparam logic [7:0] FC_TAB [10] = '{8'hfd, 8'hcb, 8'h8b, 8'h4b, 8'hc3, 8'h83,
		8'h43, 8'h32, 8'h1e, 8'h04};
	logic                 clk, sys_rst, auto_reset_evt, step_btn_pin, reset_btn_pin;
	rrdfr_req_t           req;
	rrdfr_rsp_t           rsp;
	rrdfr_ev_t            ev_in;
	rrdfr_trip_t          trip_lo, trip_hi;
	rrdfr_diag_t          diag;
	logic [4:0][9:0]      knob_set;
	logic [4:0][13:0]     active_set, remote_eff;
	logic                 irf_led, ss_relay, prot_inhibit, got, er;
	logic [7:0]           fault_code, phase_fault_record, own;
	logic [31:0]          dt;
	int                   failures = 0, checks_done = 0, cyc = 0;
	rrdfr_host_model u_host (.clk(clk), .req(req), .rsp(rsp));
	rrdfr_top #(.MS_CYCLES(4), .SST_MS(3)) dut (.clk(clk), .sys_rst(sys_rst), .req(req),
		.rsp(rsp), .ev_in(ev_in), .auto_reset_evt(auto_reset_evt), .trip_lo(trip_lo),
		.trip_hi(trip_hi), .diag(diag), .knob_set(knob_set), .step_btn_pin(step_btn_pin),
		.reset_btn_pin(reset_btn_pin), .active_set(active_set), .remote_eff(remote_eff),
		.irf_led(irf_led), .ss_relay(ss_relay), .prot_inhibit(prot_inhibit),
		.fault_code(fault_code), .phase_fault_record(phase_fault_record));
	always #10 clk = ~clk;
	task automatic print_verdict();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	// the ceiling is far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			failures++;
			print_verdict();
		end
	end
	task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic acc(input rrdfr_kind_t k, input logic [7:0] it, input logic [15:0] wd);
		u_host.xfer(k, own, it, wd, got, er, dt);
	endtask : acc
	task automatic rd(input string nm, input rrdfr_kind_t k, input logic [7:0] it,
		input logic [31:0] exp);
		acc(k, it, 16'h0000);
		check(nm, {got, er, dt}, {2'b10, exp});
	endtask : rd
	task automatic wr(input rrdfr_kind_t k, input logic [7:0] it, input logic [15:0] wd,
		input logic e);
		acc(k, it, wd);
		check("write answer", {got, er}, {1'b1, e});
	endtask : wr
	task automatic rst();
		sys_rst <= 1'b1;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
	endtask : rst
	task automatic ev(input logic [3:0] c, input logic [7:0] k);
		@(posedge clk) ev_in <= '{1'b1, c, k};
		@(posedge clk) ev_in <= '0;
	endtask : ev
	task automatic trip(input logic hi, input logic [2:0] ph);
		@(posedge clk);
		if (hi) trip_hi <= '{1'b1, ph};
		else trip_lo <= '{1'b1, ph};
		@(posedge clk);
		trip_lo <= '0;
		trip_hi <= '0;
		@(posedge clk);
		#1;
	endtask : trip
	initial begin
		clk = 0; sys_rst = 1; ev_in = '0; auto_reset_evt = 0; trip_lo = '0; trip_hi = '0;
		diag = '0; step_btn_pin = 0; reset_btn_pin = 0; own = 8'h01;
		for (int i = 0; i < 5; i++) knob_set[i] = 10'(200 + i);
		rst();
		rd("addr", RRDFR_K_VRD, 8'd200, 32'd1);
		rd("state", RRDFR_K_ST_RD, 8'h00, 32'd0);
		rd("pct", RRDFR_K_SRD, 8'd21, 32'd100);
		wr(RRDFR_K_VWR, 8'd200, 16'd0, 1'b1);
		wr(RRDFR_K_VWR, 8'd200, 16'd255, 1'b1);
		wr(RRDFR_K_VWR, 8'd200, 16'd254, 1'b0);
		acc(RRDFR_K_VRD, 8'd200, 16'h0000);
		check("old addr", got, 1'b0);
		own = 8'd254;
		rd("addr", RRDFR_K_VRD, 8'd200, 32'd254);
		ev(4'h3, 8'h11);
		ev(4'h5, 8'h22);
		for (int i = 0; i < 2; i++) begin
			acc(RRDFR_K_EV_RD, 8'h00, 16'h0000);
			check("event", {got, dt[31:28], dt[11:0]}, {5'h10, 12'(i ? 'h522 : 'h311)});
		end
		repeat (2) begin
			acc(RRDFR_K_EV_RR, 8'h00, 16'h0000);
			check("reread", {got, dt[11:0]}, {1'b1, 12'h522});
		end
		rd("ev empty", RRDFR_K_EV_RD, 8'h00, 32'd0);
		@(posedge clk) auto_reset_evt <= 1'b1;
		@(posedge clk) auto_reset_evt <= 1'b0;
		rd("state auto", RRDFR_K_ST_RD, 8'h00, 32'd1);
		for (int i = 0; i < 9; i++) ev(4'h1, 8'(i));
		rd("state both", RRDFR_K_ST_RD, 8'h00, 32'd3);
		wr(RRDFR_K_ST_WR, 8'h00, 16'd1, 1'b1);
		wr(RRDFR_K_ST_WR, 8'h00, 16'd0, 1'b0);
		rd("state clr", RRDFR_K_ST_RD, 8'h00, 32'd0);
		ev(4'h1, 8'h99);
		rd("state ovf", RRDFR_K_ST_RD, 8'h00, 32'd2);
		wr(RRDFR_K_TM_WR, 8'h00, 16'd60000, 1'b1);
		wr(RRDFR_K_TM_WR, 8'h00, 16'd59999, 1'b0);
		repeat (8) @(posedge clk);
		acc(RRDFR_K_TM_RD, 8'h00, 16'h0000);
		check("time wrap", {got, dt < 32'd4}, 2'b11);
		wr(RRDFR_K_SWR, 8'd21, 16'd500, 1'b1);
		wr(RRDFR_K_VWR, 8'd160, 16'd1, 1'b0);
		wr(RRDFR_K_SWR, 8'd21, 16'd1000, 1'b1);
		wr(RRDFR_K_SWR, 8'd21, 16'd999, 1'b0);
		rd("pct", RRDFR_K_SRD, 8'd21, 32'd999);
		wr(RRDFR_K_VWR, 8'd161, 16'd0, 1'b0);
		wr(RRDFR_K_SWR, 8'd21, 16'd7, 1'b1);
		wr(RRDFR_K_VWR, 8'd160, 16'd1, 1'b0);
		repeat (2) @(posedge clk);
		#1;
		check("eff", remote_eff[0], 14'd1998);
		check("act knob", active_set[0], 14'd200);
		wr(RRDFR_K_VWR, 8'd150, 16'd1, 1'b0);
		repeat (2) @(posedge clk);
		#1;
		check("act remote", active_set[0], 14'd1998);
		rd("act rd", RRDFR_K_SRD, 8'd1, 32'd1998);
		rd("knob rd", RRDFR_K_SRD, 8'd11, 32'd200);
		rd("rem rd", RRDFR_K_SRD, 8'd31, 32'd1998);
		wr(RRDFR_K_SWR, 8'd22, 16'd5, 1'b1);
		trip(1'b0, 3'b101);
		check("rec lo", phase_fault_record, 8'h05);
		trip(1'b1, 3'b010);
		check("rec hi", phase_fault_record, 8'h25);
		trip(1'b0, 3'b010);
		check("rec new", phase_fault_record, 8'h22);
		rd("rec rd", RRDFR_K_VRD, 8'd6, 32'h22);
		wr(RRDFR_K_VWR, 8'd102, 16'd1, 1'b0);
		@(posedge clk);
		#1;
		check("rec clr", phase_fault_record, 8'h00);
		trip(1'b1, 3'b111);
		@(posedge clk) {step_btn_pin, reset_btn_pin} <= 2'b11;
		repeat (5) @(posedge clk);
		{step_btn_pin, reset_btn_pin} <= 2'b00;
		#1;
		check("rec btn", phase_fault_record, 8'h00);
		wr(RRDFR_K_VWR, 8'd165, 16'd1, 1'b0);
		repeat (3) @(posedge clk);
		#1;
		check("ss on", {irf_led, ss_relay, prot_inhibit}, 3'b111);
		repeat (30) @(posedge clk);
		#1;
		check("ss off", {irf_led, prot_inhibit}, 2'b00);
		own = 8'h01;
		for (int b = 0; b < 10; b++) begin
			rst();
			@(posedge clk) diag <= 10'(1) << b;
			repeat (4) @(posedge clk);
			#1;
			check("fault", {fault_code, irf_led, ss_relay}, {FC_TAB[b], 2'b11});
			rd("fault rd", RRDFR_K_VRD, 8'd169, 32'(FC_TAB[b]));
			@(posedge clk) diag <= '0;
		end
		print_verdict();
	end
endmodule : relay_remote_data_and_fault_record_tb_top
`default_nettype wire
